// File: rtl/crystal_pin_function_select.sv
`timescale 1ns/1ns
// What this block does
// - analog disable: driver, trigger off, comparator
// - comparator pick disables digital input buffer
// - reset selects crystal input and output
// - select 111 connects pin 7 comparator
// - both clear: gpio, direction picks output
// - pin 7 oscillator driver stays attached
module crystal_pin_function_select (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output      logic [31:0] WB_DAT_O,
  output      logic        WB_ACK_O,
  input  wire logic [1:0]  PAD_IN,
  output      logic [1:0]  PAD_OUT,
  output      logic [1:0]  PAD_OE,
  output      logic [1:0]  ANALOG_CONNECT,
  output      logic        ANALOG_INPUT_SIX,
  output      logic        ANALOG_INPUT_SEVEN,
  input  wire logic        CRYSTAL_OUTPUT_DRIVE,
  input  wire logic        CRYSTAL_OUTPUT_DRIVE_EN,
  output      logic        CRYSTAL_INPUT
);
  // ==========================================================
  // registers
  // ==========================================================
  logic [1:0]  data_out_r;
  logic [1:0]  pin_direction_r;
  logic [1:0]  pin_function_select_r;
  logic [1:0]  analog_input_disable_r;
  logic [2:0]  comparator_input_select_r;
  logic [1:0]  pad_sync1_r;
  logic [1:0]  pad_sync2_r;
  logic [1:0]  pin_in_r;
  logic [31:0] dat_o_r;
  logic        ack_r;
  logic [1:0]  pad_out_r;
  logic [1:0]  pad_oe_r;
  logic [1:0]  analog_r;
  logic        six_r;
  logic        seven_r;
  logic        xin_r;

  // ==========================================================
  // bus decode
  // ==========================================================
  // ack every other cycle at most: the master releases after the ack
  wire        req     = WB_CYC_I & WB_STB_I & ~ack_r;
  // a write lands on the edge at which the master samples ack
  wire        wr_lane = WB_CYC_I & WB_STB_I & ack_r & WB_WE_I & WB_SEL_I[0];
  wire        page    = WB_ADR_I[4];
  wire [3:0]  ofs     = {WB_ADR_I[3:2], 2'b00};
  wire        lo      = (page == xpin_pkg::PAGE_LO);
  wire        hi      = (page == xpin_pkg::PAGE_HI);
  wire        wr_dout = wr_lane & lo & (ofs == xpin_pkg::OFS_DATA_OUT);
  wire        wr_dir  = wr_lane & lo & (ofs == xpin_pkg::OFS_DIR);
  wire        wr_fsel = wr_lane & lo & (ofs == xpin_pkg::OFS_FSEL);
  wire        wr_adis = wr_lane & lo & (ofs == xpin_pkg::OFS_ADIS);
  wire        wr_cmp  = wr_lane & hi & (ofs == xpin_pkg::OFS_CMPSEL);

  // ==========================================================
  // per-pin selection
  // ==========================================================
  logic [1:0] cmp_pick;
  logic [1:0] cell_out;
  logic [1:0] cell_oe;
  logic [1:0] cell_ibuf;
  logic [1:0] cell_analog;
  xpin_pkg::pin_mode_t cell_mode [xpin_pkg::NPINS];

  assign cmp_pick[1] =
    (comparator_input_select_r == xpin_pkg::CMP_PICK_SEVEN);
  assign cmp_pick[0] =
    (comparator_input_select_r == xpin_pkg::CMP_PICK_SIX);

  genvar g;
  generate
    for (g = 0; g < xpin_pkg::NPINS; g++) begin : g_pin
      // only pin 7 carries the oscillator output driver
      pin_cell u_cell (
        .pin_function_select  (pin_function_select_r[g]),
        .pin_direction        (pin_direction_r[g]),
        .analog_input_disable (analog_input_disable_r[g]),
        .comparator_picked    (cmp_pick[g]),
        .data_out             (data_out_r[g]),
        .crystal_drive        ((g == 1) & CRYSTAL_OUTPUT_DRIVE),
        .crystal_drive_en     ((g == 1) & CRYSTAL_OUTPUT_DRIVE_EN),
        .pad_out              (cell_out[g]),
        .pad_oe               (cell_oe[g]),
        .input_buffer_en      (cell_ibuf[g]),
        .analog_connect       (cell_analog[g]),
        .mode                 (cell_mode[g])
      );
    end
  endgenerate

  // ==========================================================
  // read mux
  // ==========================================================
  wire [31:0] status_word = {24'h000000, 2'b00,
                             cell_ibuf, cell_mode[1], cell_mode[0]};
  wire [31:0] rd_lo =
    (ofs == xpin_pkg::OFS_DATA_OUT) ? {30'h0, data_out_r} :
    (ofs == xpin_pkg::OFS_DIR)      ? {30'h0, pin_direction_r} :
    (ofs == xpin_pkg::OFS_FSEL)     ? {30'h0, pin_function_select_r} :
                                      {30'h0, analog_input_disable_r};
  // unmapped page-1 slot reads zero
  wire [31:0] rd_hi =
    (ofs == xpin_pkg::OFS_CMPSEL) ? {29'h0, comparator_input_select_r} :
    (ofs == xpin_pkg::OFS_PIN_IN) ? {30'h0, pin_in_r} :
    (ofs == xpin_pkg::OFS_STATUS) ? status_word :
                                    xpin_pkg::WORD_ZERO;
  // buffer gates level; disabled buffer reads zero
  wire [1:0] pin_in_nxt = pad_sync2_r & cell_ibuf;

  // ==========================================================
  // control registers
  // ==========================================================
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      data_out_r                <= xpin_pkg::BITS2_ZERO;
      pin_direction_r           <= xpin_pkg::BITS2_ZERO;
      pin_function_select_r     <= xpin_pkg::FSEL_RESET;
      analog_input_disable_r    <= xpin_pkg::BITS2_ZERO;
      comparator_input_select_r <= xpin_pkg::CMPSEL_ZERO;
    end else begin
      if (wr_dout) data_out_r <= WB_DAT_I[1:0];
      if (wr_dir)  pin_direction_r <= WB_DAT_I[1:0];
      if (wr_fsel) pin_function_select_r <= WB_DAT_I[1:0];
      if (wr_adis) analog_input_disable_r <= WB_DAT_I[1:0];
      if (wr_cmp)  comparator_input_select_r <= WB_DAT_I[2:0];
    end
  end

  // ==========================================================
  // bus answer, one cycle after the request
  // ==========================================================
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ack_r   <= 1'b0;
      dat_o_r <= xpin_pkg::WORD_ZERO;
    end else begin
      ack_r   <= req;
      dat_o_r <= req ? (hi ? rd_hi : rd_lo) : xpin_pkg::WORD_ZERO;
    end
  end

  // ==========================================================
  // pad input synchroniser and registered pin outputs
  // ==========================================================
  // pads are asynchronous, so two flops before any gating
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      pad_sync1_r <= xpin_pkg::BITS2_ZERO;
      pad_sync2_r <= xpin_pkg::BITS2_ZERO;
      pin_in_r    <= xpin_pkg::BITS2_ZERO;
    end else begin
      pad_sync1_r <= PAD_IN;
      pad_sync2_r <= pad_sync1_r;
      pin_in_r    <= pin_in_nxt;
    end
  end

  // outputs lag control by one cycle; a static mux tolerates it
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      pad_out_r <= xpin_pkg::BITS2_ZERO;
      pad_oe_r  <= xpin_pkg::BITS2_ZERO;
      analog_r  <= xpin_pkg::BITS2_ZERO;
      six_r     <= 1'b0;
      seven_r   <= 1'b0;
      xin_r     <= 1'b0;
    end else begin
      pad_out_r <= cell_out;
      pad_oe_r  <= cell_oe;
      analog_r  <= cell_analog;
      six_r     <= cmp_pick[0];
      seven_r   <= cmp_pick[1];
      // oscillator sees pin 6 only in crystal mode
      xin_r     <= (cell_mode[0] == xpin_pkg::MODE_CRYSTAL) & pad_sync2_r[0];
    end
  end

  assign WB_DAT_O           = dat_o_r;
  assign WB_ACK_O           = ack_r;
  assign PAD_OUT            = pad_out_r;
  assign PAD_OE             = pad_oe_r;
  assign ANALOG_CONNECT     = analog_r;
  assign ANALOG_INPUT_SIX   = six_r;
  assign ANALOG_INPUT_SEVEN = seven_r;
  assign CRYSTAL_INPUT      = xin_r;
endmodule

// File: rtl/pin_cell.sv
`timescale 1ns/1ns
// one pin's function selection, purely combinational
module pin_cell (
  input  wire logic                  pin_function_select,
  input  wire logic                  pin_direction,
  input  wire logic                  analog_input_disable,
  input  wire logic                  comparator_picked,
  input  wire logic                  data_out,
  input  wire logic                  crystal_drive,
  input  wire logic                  crystal_drive_en,
  output      logic                  pad_out,
  output      logic                  pad_oe,
  output      logic                  input_buffer_en,
  output      logic                  analog_connect,
  output      xpin_pkg::pin_mode_t   mode
);
  // ==========================================================
  // mode decode
  // ==========================================================
  // analog wins over everything, then the oscillator, then gpio
  assign mode = analog_input_disable ? xpin_pkg::MODE_ANALOG :
                pin_function_select  ? xpin_pkg::MODE_CRYSTAL :
                                       xpin_pkg::MODE_GPIO;
  wire is_gpio    = (mode == xpin_pkg::MODE_GPIO);
  wire is_crystal = (mode == xpin_pkg::MODE_CRYSTAL);

  assign analog_connect = analog_input_disable | comparator_picked;
  // direction only in gpio; oscillator keeps the pin
  assign pad_oe  = is_gpio ? pin_direction :
                   (is_crystal & crystal_drive_en);
  assign pad_out = is_gpio ? data_out : (is_crystal & crystal_drive);
  assign input_buffer_en = ~analog_input_disable & ~comparator_picked;
endmodule

// File: rtl/xpin_pkg.sv
package xpin_pkg;
  // ==========================================================
  // register map, byte offsets of 32-bit words on the wishbone bus
  // ==========================================================
  localparam logic [3:0] OFS_DATA_OUT = 4'h0;   // port output data
  localparam logic [3:0] OFS_DIR      = 4'h4;   // pin_direction
  localparam logic [3:0] OFS_FSEL     = 4'h8;   // pin_function_select
  localparam logic [3:0] OFS_ADIS     = 4'hC;   // analog_input_disable
  localparam logic [3:0] OFS_CMPSEL   = 4'h0;   // comparator select, page 1
  localparam logic [3:0] OFS_PIN_IN   = 4'h4;   // pin input, page 1
  localparam logic [3:0] OFS_STATUS   = 4'h8;   // pin mode status, page 1
  localparam logic       PAGE_LO      = 1'b0;
  localparam logic       PAGE_HI      = 1'b1;

  // ==========================================================
  // field layout and reset values
  // ==========================================================
  localparam int          NPINS       = 2;     // pin 6 (index 0), pin 7 (1)
  localparam logic [1:0]  FSEL_RESET  = 2'h3;  // crystal functions on both
  localparam logic [1:0]  BITS2_ZERO  = 2'h0;
  localparam logic [2:0]  CMPSEL_ZERO = 3'h0;
  localparam logic [2:0]  CMP_PICK_SIX   = 3'h6;  // selects analog input six
  localparam logic [2:0]  CMP_PICK_SEVEN = 3'h7;  // selects analog input seven
  localparam logic [31:0] WORD_ZERO   = 32'h0;

  // pin modes, gray coded along gpio -> crystal -> analog
  typedef enum logic [1:0] {
    MODE_GPIO    = 2'b00,
    MODE_CRYSTAL = 2'b01,
    MODE_ANALOG  = 2'b11
  } pin_mode_t;
endpackage

// File: tb/pad_world.sv
`timescale 1ns/1ns
// ==========================================
// pads and oscillator beyond the pins
module pad_world (
  input  wire logic       clk,
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe,
  input  wire logic [1:0] ext_level,
  output      logic [1:0] pad_in,
  output      logic       osc_drive,
  output      logic       osc_en
);
  // driven pin wins, else the outside source sets the level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
  assign osc_en = 1'b1;
  // oscillator stage toggles every cycle, so a stale copy shows
  initial osc_drive = 1'b0;
  always @(posedge clk) osc_drive <= ~osc_drive;
endmodule

// File: tb/tb.sv
`timescale 1ns/1ns
// ==========================================
// bench for the crystal pin selector
module tb;
  logic MCLK, RESETN, cyc, stb, we, ack, six, seven, crystal_input, odrv, oen;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [1:0]  pin, pout, poe, acon, ext;
  int          n_errors = 0;
  int          checks_done = 0;
  crystal_pin_function_select dut (.MCLK(MCLK), .RESETN(RESETN),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PAD_IN(pin), .PAD_OUT(pout), .PAD_OE(poe), .ANALOG_CONNECT(acon),
    .ANALOG_INPUT_SIX(six), .ANALOG_INPUT_SEVEN(seven),
    .CRYSTAL_OUTPUT_DRIVE(odrv), .CRYSTAL_OUTPUT_DRIVE_EN(oen),
    .CRYSTAL_INPUT(crystal_input));
  pad_world pads (.clk(MCLK), .pad_out(pout), .pad_oe(poe),
    .ext_level(ext), .pad_in(pin), .osc_drive(odrv), .osc_en(oen));
  // clock
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle: raised after an edge, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge MCLK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    // data taken and request dropped at the edge that showed ack
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // pin outputs lag the register by one cycle, the pin-in path by three
  task automatic pins(input logic [1:0] oe, input logic [1:0] ac);
    repeat (4) @(posedge MCLK);
    @(negedge MCLK);
    chk({28'h0, acon, poe}, {28'h0, ac, oe});
  endtask
  task automatic t_reset;
    rd(5'h08, 32'h3);
    rd(5'h18, 32'h35);
    rd(5'h1C, 32'h0);
    pins(2'b10, 2'b00);
    chk({31'h0, crystal_input}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_gpio;
    bus(1'b1, 5'h08, 32'h0);
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h00, 32'h2);
    pins(2'b11, 2'b00);
    chk({30'h0, pout}, 32'h2);
    chk({31'h0, crystal_input}, 32'h0);
    bus(1'b1, 5'h04, 32'h0);
    pins(2'b00, 2'b00);
    rd(5'h14, 32'h1);
    rd(5'h18, 32'h30);
    $display("gpio test done");
  endtask
  task automatic t_analog;
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h0C, 32'h1);
    pins(2'b10, 2'b01);
    rd(5'h14, 32'h2);
    rd(5'h18, 32'h23);
    $display("analog test done");
  endtask
  task automatic t_cmp;
    bus(1'b1, 5'h0C, 32'h0);
    bus(1'b1, 5'h10, 32'h7);
    pins(2'b11, 2'b10);
    chk({30'h0, six, seven}, 32'h1);
    rd(5'h14, 32'h0);
    rd(5'h18, 32'h10);
    bus(1'b1, 5'h10, 32'h6);
    pins(2'b11, 2'b01);
    chk({30'h0, six, seven}, 32'h2);
    $display("comparator test done");
  endtask
  // direction set but both pins back on the oscillator
  task automatic t_crystal;
    bus(1'b1, 5'h10, 32'h0);
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h08, 32'h3);
    pins(2'b10, 2'b00);
    chk({31'h0, pout[1]}, {31'h0, ~odrv});
    chk({31'h0, crystal_input}, 32'h1);
    rd(5'h18, 32'h35);
    $display("crystal test done");
  endtask
  // reset again in mid-run restores the crystal default
  task automatic t_rerun;
    @(posedge MCLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge MCLK);
    RESETN <= 1'b1;
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h3);
    rd(5'h10, 32'h0);
    pins(2'b10, 2'b00);
    $display("reset rerun test done");
  endtask
  // main sequence
  initial begin
    RESETN = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'hF;
    wdat = 32'h0;
    ext = 2'b01;
    repeat (6) @(posedge MCLK);
    RESETN <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_gpio();
    t_analog();
    t_cmp();
    t_crystal();
    t_rerun();
    give_verdict();
  end
endmodule

// File: tb/xpin_props.sv
`timescale 1ns/1ns
// ==========================================
// pin selection checker
module xpin_props (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic [1:0]  PAD_OE,
  input wire logic [1:0]  ANALOG_CONNECT,
  input wire logic        ANALOG_INPUT_SIX,
  input wire logic        ANALOG_INPUT_SEVEN,
  input wire logic        CRYSTAL_OUTPUT_DRIVE_EN
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  logic [1:0] age_r;
  logic       touched_r;
  // age since reset and first write; the default check ends at any write
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      age_r <= 2'h0;
      touched_r <= 1'b0;
    end else begin
      if (age_r != 2'h3)
        age_r <= age_r + 2'h1;
      if (WB_ACK_O && WB_WE_I)
        touched_r <= 1'b1;
    end
  end
  // bus answer timing
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack missing");
  chk_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data without ack");
  chk_reset_quiet: assert property (disable iff (1'b0) !RESETN |=>
    PAD_OE == 2'h0 && ANALOG_CONNECT == 2'h0 && !WB_ACK_O)
    else $error("outputs live in reset");
  chk_default_xtal: assert property (age_r == 2'h3 && !touched_r |->
    PAD_OE == {$past(CRYSTAL_OUTPUT_DRIVE_EN), 1'b0}
    && ANALOG_CONNECT == 2'h0) else $error("default not crystal");
  chk_six_route: assert property (ANALOG_INPUT_SIX |-> ANALOG_CONNECT[0])
    else $error("pin6 pick not routed");
  chk_seven_route: assert property (ANALOG_INPUT_SEVEN |->
    ANALOG_CONNECT[1] && !ANALOG_INPUT_SIX)
    else $error("pin7 pick not routed");
  chk_adis6_off: assert property (ANALOG_CONNECT[0] && !ANALOG_INPUT_SIX
    |-> !PAD_OE[0]) else $error("pin6 driven in analog");
  chk_adis7_off: assert property (
    ANALOG_CONNECT[1] && !ANALOG_INPUT_SEVEN
    |-> !PAD_OE[1]) else $error("pin7 driven in analog");
  cov_write: cover property (WB_ACK_O && WB_WE_I);
  cov_seven: cover property (ANALOG_INPUT_SEVEN);
  cov_adis: cover property (ANALOG_CONNECT[0] && !ANALOG_INPUT_SIX);
endmodule
bind crystal_pin_function_select xpin_props u_props (.MCLK, .RESETN,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ACK_O, .WB_DAT_O, .PAD_OE,
  .ANALOG_CONNECT, .ANALOG_INPUT_SIX, .ANALOG_INPUT_SEVEN,
  .CRYSTAL_OUTPUT_DRIVE_EN);
